/* File: stp_indexer.sv */
// Purpose: step/direction indexer driving two single h-bridge power stages
// Assumes: pins synchronous to pclk but still passed through two flops
// Notes: configuration straps are caught on the first edge after reset release
`timescale 1ns/10ps
module stp_indexer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic motor_enable,
   input wire logic direction,
   input wire logic step,
   input wire logic index_clear,
   input wire logic stage_reset_n,
   input wire logic stage_lowpower_n,
   input wire logic [2:0] microstep_select,
   input wire logic [4:0] preset_high,
   input wire logic drive_select,
   input wire logic host_link_select,
   output stp_pkg::stp_stage_s stage_a_out,
   output stp_pkg::stp_stage_s stage_b_out,
   output logic stage_oe,
   output logic [8:0] phase_a_index,
   output logic [8:0] phase_b_index,
   output logic index_oe
);
   // -------------------------------------------------
   // input gating and synchronisers
   // -------------------------------------------------
   logic [stp_pkg::IN_W-1:0] raw_in;
   logic [stp_pkg::IN_W-1:0] sync1_reg;
   logic [stp_pkg::IN_W-1:0] sync2_reg;
   logic [stp_pkg::IN_W-1:0] prev_reg;
   logic [stp_pkg::IN_W-1:0] rise;
   logic [stp_pkg::IN_W-1:0] fall;
   logic [stp_pkg::PRESET_W-1:0] gated;
   logic [2:0] prime_reg;
   logic primed;

   // preselected inputs read low when their switch sits at the low side
   assign gated = preset_high & {microstep_select, stage_lowpower_n, stage_reset_n};
   assign raw_in = {gated[4:2], gated[1], gated[0], index_clear, step, direction,
                    motor_enable};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         prev_reg <= '0;
      end else begin
         sync1_reg <= raw_in;
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end

   // marks when the third flop holds a real pin sample, three edges after release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prime_reg <= '0;
      end else begin
         prime_reg <= {prime_reg[1:0], 1'b1};
      end
   end

   assign primed = prime_reg[2];

   // edges come from the second and third flops only; a pin already high at
   // release is a level, not an edge, so no false step or enable follows reset
   assign rise = sync2_reg & ~prev_reg & {stp_pkg::IN_W{primed}};
   assign fall = ~sync2_reg & prev_reg & {stp_pkg::IN_W{primed}};

   // -------------------------------------------------
   // strap capture and mode
   // -------------------------------------------------
   stp_pkg::stp_mode_e mode_reg;
   logic drive_on_reg;
   logic cfg_done;
   logic host_mode;

   // straps taken on the first edge after release, never under reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= stp_pkg::STP_CFG_WAIT;
         drive_on_reg <= 1'b0;
      end else begin
         case (mode_reg)
            stp_pkg::STP_CFG_WAIT: begin
               drive_on_reg <= drive_select;
               mode_reg <= host_link_select ? stp_pkg::STP_RUN_INDEX
                                            : stp_pkg::STP_RUN_HOST;
            end
            default: begin
               mode_reg <= mode_reg;
            end
         endcase
      end
   end

   assign cfg_done = (mode_reg != stp_pkg::STP_CFG_WAIT);
   assign host_mode = (mode_reg == stp_pkg::STP_RUN_HOST);

   // -------------------------------------------------
   // apb slave
   // -------------------------------------------------
   logic [31:0] ctrl_reg;
   logic [31:0] prdata_reg;
   logic err_reg;
   logic setup;
   logic wr_ok;
   logic host_step;
   logic mapped;
   logic [31:0] status_word;

   assign setup = psel & ~penable;
   assign mapped = (paddr == stp_pkg::ADDR_CTRL) || (paddr == stp_pkg::ADDR_STEP) ||
                   (paddr == stp_pkg::ADDR_STATUS);
   // zero wait states: every access phase completes at once
   assign pready = 1'b1;
   assign pslverr = err_reg;
   assign prdata = prdata_reg;
   assign wr_ok = psel & penable & pwrite & mapped;
   assign host_step = wr_ok & (paddr == stp_pkg::ADDR_STEP) & host_mode;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= '0;
         err_reg <= 1'b0;
      end else if (setup) begin
         err_reg <= ~mapped;
         if (!pwrite && paddr == stp_pkg::ADDR_CTRL) begin
            prdata_reg <= ctrl_reg;
         end else if (!pwrite && paddr == stp_pkg::ADDR_STATUS) begin
            prdata_reg <= status_word;
         end else begin
            prdata_reg <= '0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= stp_pkg::CTRL_RESET;
      end else if (wr_ok && paddr == stp_pkg::ADDR_CTRL) begin
         ctrl_reg <= pwdata & stp_pkg::CTRL_MASK;
      end
   end

   // -------------------------------------------------
   // resolution select
   // -------------------------------------------------
   logic [2:0] ms_index;
   logic [8:0] step_size;

   // pins act at once in indexer mode; host mode uses its own field
   assign ms_index = host_mode ? ctrl_reg[stp_pkg::CTRL_MS_LO +: 3]
                               : sync2_reg[stp_pkg::IN_MS_LO +: 3];
   // index 0 steps by one of 512, index 7 steps by 128 (four per cycle)
   assign step_size = stp_pkg::IDX_UNIT << ms_index;

   // -------------------------------------------------
   // indexer state: enable, direction, clear, position
   // -------------------------------------------------
   logic en_reg;
   logic dir_reg;
   logic clr_reg;
   logic [8:0] idx_reg;
   logic idx_step;
   logic idx_dir;
   logic indexer;

   assign indexer = (mode_reg == stp_pkg::STP_RUN_INDEX);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_reg <= 1'b0;
      end else if (indexer && rise[stp_pkg::IN_ENA]) begin
         en_reg <= 1'b1;
      end else if (indexer && fall[stp_pkg::IN_ENA]) begin
         en_reg <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_reg <= 1'b1;
      end else if (indexer && rise[stp_pkg::IN_DIR]) begin
         dir_reg <= 1'b1;
      end else if (indexer && fall[stp_pkg::IN_DIR]) begin
         dir_reg <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clr_reg <= 1'b0;
      end else if (indexer && rise[stp_pkg::IN_CLR]) begin
         clr_reg <= 1'b1;
      end else if (indexer && fall[stp_pkg::IN_CLR]) begin
         clr_reg <= 1'b0;
      end
   end

   // steps are ignored while the indexer is held in clear
   assign idx_step = indexer ? (rise[stp_pkg::IN_STEP] & ~clr_reg) : host_step;
   assign idx_dir = indexer ? dir_reg : pwdata[stp_pkg::STEP_DIR];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idx_reg <= stp_pkg::IDX_ZERO;
      end else if (clr_reg) begin
         idx_reg <= stp_pkg::IDX_ZERO;
      end else if (idx_step && idx_dir) begin
         idx_reg <= idx_reg + step_size;
      end else if (idx_step) begin
         idx_reg <= idx_reg - step_size;
      end
   end

   // -------------------------------------------------
   // stage outputs
   // -------------------------------------------------
   stp_pkg::stp_stage_s a_next;
   stp_pkg::stp_stage_s b_next;
   stp_pkg::stp_stage_s a_reg;
   stp_pkg::stp_stage_s b_reg;
   logic [8:0] pa_reg;
   logic [8:0] pb_reg;
   logic oe_reg;
   logic coord;

   assign coord = ctrl_reg[stp_pkg::CTRL_COORD];

   always_comb begin
      a_next = '0;
      b_next = '0;
      if (host_mode) begin
         // coordinated mode drives stage b from the stage a bits
         a_next.enable = ctrl_reg[stp_pkg::CTRL_EN_A];
         a_next.reset_n = ctrl_reg[stp_pkg::CTRL_RST_A];
         a_next.lowpower_n = ctrl_reg[stp_pkg::CTRL_LP_A];
         b_next.enable = ctrl_reg[coord ? stp_pkg::CTRL_EN_A : stp_pkg::CTRL_EN_B];
         b_next.reset_n = ctrl_reg[coord ? stp_pkg::CTRL_RST_A : stp_pkg::CTRL_RST_B];
         b_next.lowpower_n = ctrl_reg[coord ? stp_pkg::CTRL_LP_A : stp_pkg::CTRL_LP_B];
      end else begin
         a_next.enable = en_reg & ~clr_reg;
         a_next.reset_n = 1'b1;
         a_next.lowpower_n = 1'b1;
         b_next = a_next;
      end
      // the pins override host commands, so a low pin always wins
      a_next.reset_n = a_next.reset_n & sync2_reg[stp_pkg::IN_RST];
      b_next.reset_n = b_next.reset_n & sync2_reg[stp_pkg::IN_RST];
      a_next.lowpower_n = a_next.lowpower_n & sync2_reg[stp_pkg::IN_LP];
      b_next.lowpower_n = b_next.lowpower_n & sync2_reg[stp_pkg::IN_LP];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         a_reg <= '0;
         b_reg <= '0;
         pa_reg <= stp_pkg::IDX_ZERO;
         pb_reg <= stp_pkg::IDX_QUARTER;
         oe_reg <= 1'b0;
      end else begin
         a_reg <= a_next;
         b_reg <= b_next;
         pa_reg <= idx_reg;
         // phase b leads by a quarter cycle to read the cosine
         pb_reg <= idx_reg + stp_pkg::IDX_QUARTER;
         oe_reg <= cfg_done & drive_on_reg;
      end
   end

   assign stage_a_out = a_reg;
   assign stage_b_out = b_reg;
   assign phase_a_index = pa_reg;
   assign phase_b_index = pb_reg;
   assign stage_oe = oe_reg;
   assign index_oe = oe_reg;

   // -------------------------------------------------
   // status word
   // -------------------------------------------------
   always_comb begin
      status_word = '0;
      status_word[stp_pkg::IDX_W-1:0] = idx_reg;
      status_word[stp_pkg::ST_DIR] = dir_reg;
      status_word[stp_pkg::ST_EN] = en_reg;
      status_word[stp_pkg::ST_CLR] = clr_reg;
      status_word[stp_pkg::ST_HOST] = host_mode;
      status_word[stp_pkg::ST_DRIVE] = drive_on_reg;
      status_word[stp_pkg::ST_CFG] = cfg_done;
      status_word[stp_pkg::ST_MS_LO +: 3] = ms_index;
   end

   // -------------------------------------------------
   // assertions
   // -------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   drive_off_hiz_a: assert property (!drive_on_reg |=> !stage_oe && !index_oe)
      else $error("outputs driven while drive select was low");
   strap_stable_a: assert property (cfg_done |=> $stable(mode_reg) && $stable(drive_on_reg))
      else $error("strap setting changed after reset");
   enable_edge_a: assert property (indexer && rise[stp_pkg::IN_ENA] && !clr_reg
      ##1 !fall[stp_pkg::IN_ENA] && !clr_reg |=> stage_a_out.enable && stage_b_out.enable)
      else $error("stage enables missed a motor enable rise");
   disable_edge_a: assert property (indexer && fall[stp_pkg::IN_ENA] |=> ##1
      !stage_a_out.enable && !stage_b_out.enable)
      else $error("stage enables stayed on after motor enable fell");
   clear_holds_a: assert property (indexer && clr_reg [*2] |=> !stage_a_out.enable)
      else $error("stage enable high during indexer clear");
   clear_zero_a: assert property (indexer && fall[stp_pkg::IN_CLR] |=> idx_reg == 9'h000)
      else $error("index not zero after clear released");
   step_advance_a: assert property (idx_step && !clr_reg |=>
      idx_reg == ($past(idx_dir) ? $past(idx_reg) + $past(step_size)
                                 : $past(idx_reg) - $past(step_size)))
      else $error("index moved by the wrong amount");
   no_edge_still_a: assert property (indexer && !rise[stp_pkg::IN_STEP] && !clr_reg |=>
      $stable(idx_reg))
      else $error("index moved without a step edge");
   coarse_size_a: assert property (ms_index == 3'h7 |-> step_size == 9'h080)
      else $error("coarsest resolution does not give four steps per cycle");
   host_ms_a: assert property (host_mode |-> ms_index == ctrl_reg[10:8])
      else $error("microstep pins used in host mode");
   reset_pin_a: assert property (!sync2_reg[stp_pkg::IN_RST] |=>
      !stage_a_out.reset_n && !stage_b_out.reset_n)
      else $error("stages left out of reset while reset pin low");
   sleep_pin_a: assert property (!sync2_reg[stp_pkg::IN_LP] |=>
      !stage_a_out.lowpower_n && !stage_b_out.lowpower_n)
      else $error("stages awake while low-power pin low");
   dir_edge_a: assert property (indexer && rise[stp_pkg::IN_DIR] |=> dir_reg)
      else $error("direction not forward after rising edge");
   phase_gap_a: assert property (cfg_done ##1 cfg_done |-> phase_b_index == phase_a_index
      + 9'h080)
      else $error("phase b not a quarter cycle ahead");
endmodule // stp_indexer

/* File: stp_pkg.sv */
// Purpose: shared constants and types for the step/direction indexer
// Assumes: one clock, APB register access, 32-bit data
// Notes: input vector layout is fixed here and used by the top module
package stp_pkg;
   // -------------------------------------------------
   // register map (byte addresses)
   // -------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STEP = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   // -------------------------------------------------
   // control register fields
   // -------------------------------------------------
   localparam int CTRL_EN_A = 0;
   localparam int CTRL_EN_B = 1;
   localparam int CTRL_RST_A = 2;
   localparam int CTRL_RST_B = 3;
   localparam int CTRL_LP_A = 4;
   localparam int CTRL_LP_B = 5;
   localparam int CTRL_COORD = 6;
   localparam int CTRL_MS_LO = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_003C;
   localparam logic [31:0] CTRL_MASK = 32'h0000_077F;
   localparam int STEP_DIR = 0;
   // -------------------------------------------------
   // status register fields
   // -------------------------------------------------
   localparam int ST_DIR = 9;
   localparam int ST_EN = 10;
   localparam int ST_CLR = 11;
   localparam int ST_HOST = 12;
   localparam int ST_DRIVE = 13;
   localparam int ST_CFG = 14;
   localparam int ST_MS_LO = 16;
   // -------------------------------------------------
   // synchronised input vector layout
   // -------------------------------------------------
   localparam int IN_ENA = 0;
   localparam int IN_DIR = 1;
   localparam int IN_STEP = 2;
   localparam int IN_CLR = 3;
   localparam int IN_RST = 4;
   localparam int IN_LP = 5;
   localparam int IN_MS_LO = 6;
   localparam int IN_W = 9;
   localparam int PRESET_W = 5;
   // -------------------------------------------------
   // indexer geometry: 512 microsteps per electrical cycle
   // -------------------------------------------------
   localparam int IDX_W = 9;
   localparam logic [8:0] IDX_ZERO = 9'h000;
   localparam logic [8:0] IDX_QUARTER = 9'h080;
   localparam logic [8:0] IDX_UNIT = 9'h001;

   typedef struct packed {
      logic enable;
      logic reset_n;
      logic lowpower_n;
   } stp_stage_s;

   typedef enum logic [1:0] {
      STP_CFG_WAIT = 2'b00,
      STP_RUN_INDEX = 2'b01,
      STP_RUN_HOST = 2'b10
   } stp_mode_e;
endpackage

/* File: stp_user_ctrl.sv */
// Purpose: user controller model driving the indexer pins
// Assumes: pins change just after a rising edge of pclk
// Notes: pulse widths are chosen by the caller, so it can be prompt or slow
`timescale 1ns/10ps
module stp_user_ctrl (
   input wire logic pclk,
   output logic motor_enable,
   output logic direction,
   output logic step,
   output logic index_clear
);
   initial begin
      motor_enable = 1'b0;
      direction = 1'b1;
      step = 1'b0;
      index_clear = 1'b0;
   end
   // levels are held between calls, so every change is one clean edge
   task automatic set_levels(input logic en, input logic dir, input logic clr);
      @(posedge pclk);
      motor_enable <= en;
      direction <= dir;
      index_clear <= clr;
   endtask
   // high and low phases stay wider than the two-flop synchroniser needs
   task automatic pulse(input int hi, input int lo);
      @(posedge pclk);
      step <= 1'b1;
      repeat (hi) @(posedge pclk);
      step <= 1'b0;
      repeat (lo) @(posedge pclk);
   endtask
endmodule // stp_user_ctrl

/* File: test_stp_indexer.sv */
// Purpose: self-checking bench for the step/direction indexer
// Assumes: zero-wait apb slave, pin actions visible four edges after a pin edge
// Notes: waits after pin changes are six cycles, or four before a step pulse, to cover that latency
`timescale 1ns/10ps
module test_stp_indexer;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic motor_enable, direction, step, index_clear;
   logic stage_reset_n, stage_lowpower_n, drive_select, host_link_select;
   logic [2:0] microstep_select;
   logic [4:0] preset_high;
   stp_pkg::stp_stage_s stage_a_out, stage_b_out;
   logic stage_oe, index_oe;
   logic [8:0] phase_a_index, phase_b_index, exp_idx;
   int err_count = 0;
   int tests_run = 0;

   stp_indexer stp_indexer_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .motor_enable, .direction, .step, .index_clear,
      .stage_reset_n, .stage_lowpower_n, .microstep_select, .preset_high, .drive_select,
      .host_link_select, .stage_a_out, .stage_b_out, .stage_oe, .phase_a_index,
      .phase_b_index, .index_oe);
   stp_user_ctrl stp_user_ctrl_i (.pclk, .motor_enable, .direction, .step, .index_clear);

   always #20 pclk = ~pclk;

   task automatic complete_run();
      if (err_count == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // -------------------------------------------------
   // apb master: request held until pready is sampled
   // -------------------------------------------------
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 16) begin
         err_count++;
         complete_run();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic do_reset(input logic drv, input logic host);
      @(posedge pclk);
      presetn <= 1'b0;
      drive_select <= drv;
      host_link_select <= host;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
   endtask

   // -------------------------------------------------
   // scenarios
   // -------------------------------------------------
   task automatic sc_reset();
      do_reset(1'b1, 1'b1);
      chk("phase_a", phase_a_index, 9'h000);
      chk("phase_b", phase_b_index, 9'h080);
      chk("stage_oe", stage_oe, 1'b1);
      chk("index_oe", index_oe, 1'b1);
      apb(1'b0, stp_pkg::ADDR_CTRL, 32'h0000_0000);
      chk("ctrl", rd, stp_pkg::CTRL_RESET);
      apb(1'b0, 8'h0C, 32'h0000_0000);
      chk("unmapped_err", err, 1'b1);
      chk("unmapped_data", rd, 32'h0000_0000);
      // straps flipped while running must not change mode or drive
      host_link_select <= 1'b0;
      drive_select <= 1'b0;
      repeat (6) @(posedge pclk);
      apb(1'b0, stp_pkg::ADDR_STATUS, 32'h0000_0000);
      chk("host_mode", rd[stp_pkg::ST_HOST], 1'b0);
      chk("drive_on", rd[stp_pkg::ST_DRIVE], 1'b1);
      chk("oe_kept", stage_oe, 1'b1);
   endtask

   task automatic sc_steps();
      exp_idx = 9'h000;
      stp_user_ctrl_i.set_levels(1'b1, 1'b1, 1'b0);
      for (int ms = 0; ms < 8; ms++) begin
         microstep_select <= 3'(ms);
         repeat (4) @(posedge pclk);
         stp_user_ctrl_i.pulse(2, 4);
         exp_idx = exp_idx + 9'(1 << ms);
         chk("idx_fwd", phase_a_index, exp_idx);
         chk("phase_b", phase_b_index, exp_idx + 9'h080);
      end
      stp_user_ctrl_i.set_levels(1'b1, 1'b0, 1'b0);
      repeat (4) @(posedge pclk);
      stp_user_ctrl_i.pulse(6, 6);
      // index 7 moves a quarter cycle per step: four steps per cycle
      chk("idx_rev", phase_a_index, exp_idx - 9'h080);
      // switches at the low side make the select read as index 0
      preset_high <= 5'h03;
      repeat (4) @(posedge pclk);
      stp_user_ctrl_i.pulse(2, 4);
      chk("idx_low_sw", phase_a_index, exp_idx - 9'h081);
      preset_high <= 5'h1F;
   endtask

   task automatic sc_enable_clear();
      stp_user_ctrl_i.set_levels(1'b0, 1'b1, 1'b0);
      repeat (6) @(posedge pclk);
      chk("en_a_off", stage_a_out, 3'h3);
      stp_user_ctrl_i.set_levels(1'b1, 1'b1, 1'b0);
      repeat (6) @(posedge pclk);
      chk("en_a_on", stage_a_out, 3'h7);
      chk("en_b_on", stage_b_out, 3'h7);
      stp_user_ctrl_i.set_levels(1'b1, 1'b1, 1'b1);
      repeat (6) @(posedge pclk);
      chk("clr_en", stage_a_out, 3'h3);
      stp_user_ctrl_i.pulse(2, 4);
      chk("clr_idx", phase_a_index, 9'h000);
      stp_user_ctrl_i.set_levels(1'b1, 1'b1, 1'b0);
      repeat (6) @(posedge pclk);
      chk("clr_exit", phase_a_index, 9'h000);
      chk("clr_en_b", stage_b_out, 3'h7);
   endtask

   task automatic sc_stage_pins();
      stage_reset_n <= 1'b0;
      repeat (6) @(posedge pclk);
      chk("rst_a", stage_a_out.reset_n, 1'b0);
      chk("rst_b", stage_b_out.reset_n, 1'b0);
      stage_reset_n <= 1'b1;
      stage_lowpower_n <= 1'b0;
      repeat (6) @(posedge pclk);
      chk("lp_a", stage_a_out, 3'h6);
      chk("lp_b", stage_b_out.lowpower_n, 1'b0);
      stage_lowpower_n <= 1'b1;
      preset_high <= 5'h1E;
      repeat (6) @(posedge pclk);
      chk("rst_sw", stage_a_out.reset_n, 1'b0);
      preset_high <= 5'h1F;
   endtask

   task automatic sc_host();
      do_reset(1'b1, 1'b0);
      apb(1'b0, stp_pkg::ADDR_STATUS, 32'h0000_0000);
      chk("host_mode", rd[stp_pkg::ST_HOST], 1'b1);
      microstep_select <= 3'h7;
      apb(1'b1, stp_pkg::ADDR_CTRL, 32'h0000_023D);
      repeat (3) @(posedge pclk);
      chk("host_a", stage_a_out, 3'h7);
      chk("host_b", stage_b_out, 3'h3);
      apb(1'b1, stp_pkg::ADDR_STEP, 32'h0000_0001);
      repeat (3) @(posedge pclk);
      chk("host_step", phase_a_index, 9'h004);
      stp_user_ctrl_i.pulse(2, 4);
      chk("pin_ignored", phase_a_index, 9'h004);
      apb(1'b1, stp_pkg::ADDR_STEP, 32'h0000_0000);
      repeat (3) @(posedge pclk);
      chk("host_rev", phase_a_index, 9'h000);
      apb(1'b1, stp_pkg::ADDR_CTRL, 32'h0000_007D);
      repeat (3) @(posedge pclk);
      chk("coord_b", stage_b_out, 3'h7);
   endtask

   task automatic sc_bypass();
      do_reset(1'b0, 1'b1);
      repeat (2) @(posedge pclk);
      chk("bypass_st", stage_oe, 1'b0);
      chk("bypass_ix", index_oe, 1'b0);
   endtask

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      stage_reset_n = 1'b1;
      stage_lowpower_n = 1'b1;
      microstep_select = 3'h0;
      preset_high = 5'h1F;
      drive_select = 1'b1;
      host_link_select = 1'b1;
      sc_reset();
      do_reset(1'b1, 1'b1);
      sc_steps();
      sc_enable_clear();
      sc_stage_pins();
      sc_host();
      sc_bypass();
      complete_run();
   end
endmodule // test_stp_indexer
